/* logic/sdram_mode_cfg.sv */
// mode-register fields, calibration readout and latency timing of the memory device
`timescale 1ns/1ps
`include "sdram_mode_consts.svh"

// Contract
// - write CAS delay comes from mode register two bits A3 to A5
// - total write delay is additive delay plus write CAS delay, whole cycles
// - A6 set: thermal sensor picks self-refresh rate and A7 ignored
// - A6 clear: A7 picks normal or normal-plus-extended rate
// - mode register two A9 and A10 set write-time dynamic termination
// - during write leveling only nominal termination, no dynamic value
// - mode set with bank bits 011 writes mode register three
// - readout location ignored when calibration readout is off
// - with readout on, every read returns the calibration pattern
// - reset still works while calibration readout is on
// - chip select low, others high is a no-operation
// - chip select high deselects, no new command runs
// - mode register one A0 set disables DLL until cleared
// - DLL-off mode needs only read and write CAS delay of six
// - DLL-off reads start one cycle earlier than additive plus read delay
// - A4:A3 give additive delay 0, read delay minus one or two
// - mode set with bank bits 010 writes mode register two
module sdram_mode_cfg
  import sdram_mode_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  input  wire logic        CK,
  input  wire logic        CS_N,
  input  wire logic        RAS_N,
  input  wire logic        CAS_N,
  input  wire logic        WE_N,
  input  wire logic [2:0]  BA,
  input  wire logic [14:0] ADDR,
  input  wire logic        THERMAL_HOT,
  output logic             READ_DATA_START,
  output logic             READ_FROM_CALIB,
  output logic             WRITE_DATA_START,
  output logic [1:0]       CALIB_LOCATION,
  output logic [1:0]       RTT_WR_ACTIVE,
  output logic             SR_RATE_EXTENDED,
  output logic             DLL_ENABLED,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [23:0] pins_s1_q;
  logic [23:0] pins_s2_q;
  logic        ck_prev_q;
  wire  [23:0] pins_raw = {THERMAL_HOT, ADDR, BA, WE_N, CAS_N, RAS_N, CS_N, CK};

  // two stages for every pin; the first stage feeds only the second
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      pins_s1_q <= '0;
      pins_s2_q <= '0;
      ck_prev_q <= 1'b0;
    end else begin
      pins_s1_q <= pins_raw;
      pins_s2_q <= pins_s1_q;
      ck_prev_q <= pins_s2_q[0];
    end
  end

  wire        ck_rise  = pins_s2_q[0] & ~ck_prev_q;
  wire        cs_n_s   = pins_s2_q[1];
  wire        ras_n_s  = pins_s2_q[2];
  wire        cas_n_s  = pins_s2_q[3];
  wire        we_n_s   = pins_s2_q[4];
  wire [2:0]  ba_s     = pins_s2_q[7:5];
  wire [14:0] addr_s   = pins_s2_q[22:8];
  wire        hot_s    = pins_s2_q[23];

  // ------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------
  cmd_type cmd;
  // deselect and no-operation fall through to nothing; work in flight keeps going
  always_comb begin
    if (cs_n_s)                                cmd = CMD_DESELECT;
    else if (ras_n_s & cas_n_s & we_n_s)       cmd = CMD_NOP;
    else if (!ras_n_s && !cas_n_s && !we_n_s)  cmd = CMD_MODE_SET;
    else if (ras_n_s && !cas_n_s && we_n_s)    cmd = CMD_READ;
    else if (ras_n_s && !cas_n_s && !we_n_s)   cmd = CMD_WRITE;
    else                                       cmd = CMD_OTHER;
  end

  wire take_cmd  = ck_rise;
  wire set_one   = take_cmd && (cmd == CMD_MODE_SET) && (ba_s == `BA_MODE_ONE);
  wire set_two   = take_cmd && (cmd == CMD_MODE_SET) && (ba_s == `BA_MODE_TWO);
  wire set_three = take_cmd && (cmd == CMD_MODE_SET) && (ba_s == `BA_MODE_THREE);
  wire do_read   = take_cmd && (cmd == CMD_READ);
  wire do_write  = take_cmd && (cmd == CMD_WRITE);

  // ------------------------------------------------------------
  // mode register fields
  // ------------------------------------------------------------
  logic       dll_off_q;
  logic [1:0] al_code_q;
  logic       wlevel_q;
  logic [2:0] cwl_code_q;
  logic       asr_q;
  logic       srt_q;
  logic [1:0] rtt_wr_q;
  logic       calib_en_q;
  logic [1:0] calib_loc_q;

  // reserved bits are not stored; the controller keeps them at zero
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      dll_off_q   <= `RST_FIELD;
      al_code_q   <= '0;
      wlevel_q    <= `RST_FIELD;
      cwl_code_q  <= '0;
      asr_q       <= `RST_FIELD;
      srt_q       <= `RST_FIELD;
      rtt_wr_q    <= '0;
      calib_en_q  <= `RST_FIELD;
      calib_loc_q <= '0;
    end else begin
      if (set_one) begin
        dll_off_q <= addr_s[`POS_DLL_OFF];
        al_code_q <= addr_s[`POS_AL_HI:`POS_AL_LO];
        wlevel_q  <= addr_s[`POS_WLEVEL];
      end
      if (set_two) begin
        cwl_code_q <= addr_s[`POS_CWL_HI:`POS_CWL_LO];
        asr_q      <= addr_s[`POS_ASR];
        srt_q      <= addr_s[`POS_SRT];
        rtt_wr_q   <= addr_s[`POS_RTT_WR_HI:`POS_RTT_WR_LO];
      end
      if (set_three) begin
        calib_en_q  <= addr_s[`POS_CALIB_EN];
        calib_loc_q <= addr_s[`POS_CALIB_LOC_HI:0];
      end
    end
  end

  // ------------------------------------------------------------
  // latency arithmetic
  // ------------------------------------------------------------
  lat_type read_cas_q;
  lat_type write_cas_delay;
  lat_type additive_delay;
  lat_type total_write_delay;
  lat_type read_delay;

  // codes outside the speed grade's set are not checked here
  assign write_cas_delay = `CWL_BASE + lat_type'(cwl_code_q);
  assign additive_delay  = (al_code_q == `AL_CL_MINUS_ONE) ? read_cas_q - 5'h01 :
                           (al_code_q == `AL_CL_MINUS_TWO) ? read_cas_q - 5'h02 : 5'h00;
  assign total_write_delay = additive_delay + write_cas_delay;
  // without the DLL the strobe is tied to the edge one cycle earlier
  assign read_delay = additive_delay + read_cas_q - (dll_off_q ? `DLL_OFF_ADVANCE : 5'h00);
  wire dll_off_unsupported = dll_off_q &&
                             ((read_cas_q != `DLL_OFF_CL) || (write_cas_delay != `DLL_OFF_CWL));

  // ------------------------------------------------------------
  // read and write start pipes, one bit per pending link cycle
  // ------------------------------------------------------------
  pipe_type rd_pipe_q;
  pipe_type rd_calib_q;
  pipe_type wr_pipe_q;
  wire pipe_type rd_pipe_d  = {1'b0, rd_pipe_q[31:1]} | (do_read ? pipe_type'(1) << read_delay : '0);
  wire pipe_type rd_calib_d = {1'b0, rd_calib_q[31:1]} |
                              ((do_read && calib_en_q) ? pipe_type'(1) << read_delay : '0);
  wire pipe_type wr_pipe_d  = {1'b0, wr_pipe_q[31:1]} |
                              (do_write ? pipe_type'(1) << total_write_delay : '0);

  // overlapping commands each keep their own bit, so bursts may queue
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rd_pipe_q  <= '0;
      rd_calib_q <= '0;
      wr_pipe_q  <= '0;
    end else if (ck_rise) begin
      rd_pipe_q  <= rd_pipe_d;
      rd_calib_q <= rd_calib_d;
      wr_pipe_q  <= wr_pipe_d;
    end
  end

  // ------------------------------------------------------------
  // device-side outputs
  // ------------------------------------------------------------
  // dynamic termination is masked while write leveling is on
  wire [1:0] rtt_wr_d = wlevel_q ? 2'h0 : rtt_wr_q;
  // the sensor overrides the manual range bit when auto refresh is on
  wire       sr_ext_d = asr_q ? hot_s : srt_q;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      READ_DATA_START  <= 1'b0;
      READ_FROM_CALIB  <= 1'b0;
      WRITE_DATA_START <= 1'b0;
      CALIB_LOCATION   <= 2'h0;
      RTT_WR_ACTIVE    <= 2'h0;
      SR_RATE_EXTENDED <= 1'b0;
      DLL_ENABLED      <= 1'b1;
    end else begin
      READ_DATA_START  <= ck_rise & rd_pipe_q[1];
      READ_FROM_CALIB  <= ck_rise & rd_calib_q[1];
      WRITE_DATA_START <= ck_rise & wr_pipe_q[1];
      CALIB_LOCATION   <= calib_en_q ? calib_loc_q : 2'h0;
      RTT_WR_ACTIVE    <= rtt_wr_d;
      SR_RATE_EXTENDED <= sr_ext_d;
      DLL_ENABLED      <= ~dll_off_q;
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite register slave
  // ------------------------------------------------------------
  logic        aw_held_q;
  logic        w_held_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;

  wire aw_take   = S_AXI_AWVALID & S_AXI_AWREADY;
  wire w_take    = S_AXI_WVALID & S_AXI_WREADY;
  wire wr_fire   = aw_held_q & w_held_q & ~S_AXI_BVALID;
  wire wr_cfg    = wr_fire && (aw_addr_q == `OFS_LATENCY_CFG);
  wire wr_map_ok = (aw_addr_q == `OFS_LATENCY_CFG) || (aw_addr_q == `OFS_MODE_STATUS) ||
                   (aw_addr_q == `OFS_LATENCY_STATUS);

  // address and data are held apart, so either may arrive first
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
      if (w_take) begin
        w_held_q <= 1'b1;
        w_data_q <= S_AXI_WDATA;
        w_strb_q <= S_AXI_WSTRB;
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // write response and the one writable register
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `RESP_OKAY;
      read_cas_q   <= `RST_READ_CAS_DELAY;
    end else begin
      if (wr_fire) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_map_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
      if (wr_cfg && w_strb_q[0]) begin
        read_cas_q <= w_data_q[4:0];
      end
    end
  end

  // readiness is registered so the ports come straight from flops
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
    end else begin
      S_AXI_AWREADY <= ~aw_held_q & ~aw_take;
      S_AXI_WREADY  <= ~w_held_q & ~w_take;
    end
  end

  // read data mux; unmapped words read zero with an error response
  wire [31:0] status_word = {17'h00000, dll_off_unsupported, calib_loc_q, calib_en_q, rtt_wr_q,
                             srt_q, asr_q, cwl_code_q, wlevel_q, al_code_q, dll_off_q};
  wire [31:0] cfg_word    = {27'h0000000, read_cas_q};
  wire [31:0] lat_word    = {11'h000, read_delay, 3'h0, total_write_delay, 3'h0,
                             additive_delay};
  wire        rd_ok       = (S_AXI_ARADDR == `OFS_MODE_STATUS) || (S_AXI_ARADDR == `OFS_LATENCY_CFG) ||
                            (S_AXI_ARADDR == `OFS_LATENCY_STATUS);
  wire [31:0] rd_word     = (S_AXI_ARADDR == `OFS_MODE_STATUS)    ? status_word :
                            (S_AXI_ARADDR == `OFS_LATENCY_CFG)    ? cfg_word :
                            (S_AXI_ARADDR == `OFS_LATENCY_STATUS) ? lat_word : 32'h0000_0000;
  wire        ar_take     = S_AXI_ARVALID & S_AXI_ARREADY;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= `RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= ~S_AXI_RVALID & ~ar_take & ~S_AXI_ARREADY;
      if (ar_take) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA  <= rd_word;
        S_AXI_RRESP  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

endmodule

/* logic/sdram_mode_consts.svh */
// constants for the mode-register configuration block
`ifndef SDRAM_MODE_CONSTS_SVH
`define SDRAM_MODE_CONSTS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define OFS_MODE_STATUS    8'h00
`define OFS_LATENCY_CFG    8'h04
`define OFS_LATENCY_STATUS 8'h08

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RST_READ_CAS_DELAY 5'h06
`define RST_FIELD          1'h0

// ------------------------------------------------------------
// bank address codes of the mode registers
// ------------------------------------------------------------
`define BA_MODE_ONE   3'h1
`define BA_MODE_TWO   3'h2
`define BA_MODE_THREE 3'h3

// ------------------------------------------------------------
// address-bit field positions
// ------------------------------------------------------------
`define POS_DLL_OFF      0
`define POS_AL_LO        3
`define POS_AL_HI        4
`define POS_WLEVEL       7
`define POS_CWL_LO       3
`define POS_CWL_HI       5
`define POS_ASR          6
`define POS_SRT          7
`define POS_RTT_WR_LO    9
`define POS_RTT_WR_HI    10
`define POS_CALIB_EN     2
`define POS_CALIB_LOC_HI 1

// ------------------------------------------------------------
// timing counts in link clock cycles, and additive-delay field codes
// ------------------------------------------------------------
`define CWL_BASE         5'h05
`define DLL_OFF_ADVANCE  5'h01
`define DLL_OFF_CL       5'h06
`define DLL_OFF_CWL      5'h06
`define AL_OFF           2'h0
`define AL_CL_MINUS_ONE  2'h1
`define AL_CL_MINUS_TWO  2'h2

// ------------------------------------------------------------
// bus responses
// ------------------------------------------------------------
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

/* logic/sdram_mode_pkg.sv */
// types shared by the mode-register configuration block
package sdram_mode_pkg;
  typedef enum logic [2:0] {
    CMD_DESELECT,
    CMD_NOP,
    CMD_MODE_SET,
    CMD_READ,
    CMD_WRITE,
    CMD_OTHER
  } cmd_type;
  typedef logic [4:0]  lat_type;
  typedef logic [31:0] pipe_type;
endpackage

/* tb/sdram_ctrl_model.sv */
// controller-side model: link clock and command pins
`timescale 1ns/1ps
module sdram_ctrl_model (
  output logic        ck,
  output logic        cs_n,
  output logic        ras_n,
  output logic        cas_n,
  output logic        we_n,
  output logic [2:0]  ba,
  output logic [14:0] addr
);
  // ------------------------------------------------------------
  // link clock and command issue
  // ------------------------------------------------------------
  // free-running link clock, phase offset from the system clock
  initial begin
    ck = 1'b0;
    {cs_n, ras_n, cas_n, we_n, ba, addr} = 22'h3fffff;
    #3;
    forever #40 ck = ~ck;
  end
  // pins change on the falling edge so they are steady across the rise
  task automatic send(input logic [3:0] cmd, input logic [2:0] b, input logic [14:0] a);
    logic [14:0] m;
    m = (cmd != 4'h0) ? a : (b == 3'h3) ? (a & 15'h0007) : (b == 3'h2) ? (a & 15'h06f8) : (a & 15'h12ff);
    @(negedge ck);
    // only mode sets, reads, writes, nops and deselects go out: banks stay idle, no refresh duty arises
    {cs_n, ras_n, cas_n, we_n} = cmd;
    ba = b;
    addr = m;
    @(posedge ck);
    @(negedge ck);
    // released pins deselect and the rest show the inverse, not the last value
    {cs_n, ras_n, cas_n, we_n} = {1'b1, ~cmd[2:0]};
    ba = ~b;
    addr = ~m;
  endtask
endmodule

/* tb/sdram_mode_cfg_chk.sv */
// port-level assertions for the mode-register block
`timescale 1ns/1ps
module sdram_mode_cfg_chk (
  input wire logic        CLK_SYS,
  input wire logic        RST_N,
  input wire logic        CK,
  input wire logic        CS_N,
  input wire logic        RAS_N,
  input wire logic        CAS_N,
  input wire logic        WE_N,
  input wire logic [2:0]  BA,
  input wire logic [14:0] ADDR,
  input wire logic        THERMAL_HOT,
  input wire logic        READ_DATA_START,
  input wire logic        READ_FROM_CALIB,
  input wire logic [1:0]  CALIB_LOCATION,
  input wire logic [1:0]  RTT_WR_ACTIVE,
  input wire logic        SR_RATE_EXTENDED,
  input wire logic        DLL_ENABLED
);
  // ------------------------------------------------------------
  // command capture
  // ------------------------------------------------------------
  logic [2:0]  ck_q;
  logic [2:0]  ba_q;
  logic [14:0] a_q;
  logic [3:0]  since_q;
  logic        mrs_q;
  logic        wl_q;
  wire         rise = ck_q[1] & ~ck_q[2];
  wire         mrs  = {CS_N, RAS_N, CAS_N, WE_N} == 4'h0;
  // pins are held well past the rise, so sampling at detection is safe
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ck_q    <= 3'h0;
      ba_q    <= 3'h0;
      a_q     <= 15'h0;
      since_q <= 4'h0;
      mrs_q   <= 1'b0;
      wl_q    <= 1'b0;
    end else begin
      ck_q    <= {ck_q[1:0], CK};
      since_q <= rise ? 4'h0 : (since_q == 4'hf ? since_q : since_q + 4'h1);
      if (rise) begin
        mrs_q <= mrs;
        ba_q  <= BA;
        a_q   <= ADDR;
        wl_q  <= (mrs && BA == 3'h1) ? ADDR[7] : wl_q;
      end
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  chk_dll_cause: assert property ($changed(DLL_ENABLED) |-> mrs_q && ba_q == 3'h1 && since_q < 4'h5)
    else $error("dll state moved without a mode set");
  chk_loc_cause: assert property ($changed(CALIB_LOCATION) |-> mrs_q && ba_q == 3'h3 && since_q < 4'h5)
    else $error("location moved without a mode set");
  chk_dll_value: assert property (mrs_q && ba_q == 3'h1 && since_q == 4'h5 |-> DLL_ENABLED == !a_q[0])
    else $error("dll state wrong");
  chk_rtt_value: assert property (mrs_q && ba_q == 3'h2 && since_q == 4'h5
    |-> RTT_WR_ACTIVE == (wl_q ? 2'h0 : a_q[10:9])) else $error("termination wrong");
  chk_sr_value: assert property (mrs_q && ba_q == 3'h2 && since_q == 4'h5
    |-> SR_RATE_EXTENDED == (a_q[6] ? THERMAL_HOT : a_q[7])) else $error("refresh rate wrong");
  chk_loc_value: assert property (mrs_q && ba_q == 3'h3 && since_q == 4'h5
    |-> CALIB_LOCATION == (a_q[2] ? a_q[1:0] : 2'h0)) else $error("location wrong");
  chk_calib_pulse: assert property (READ_FROM_CALIB |-> READ_DATA_START)
    else $error("readout flag without read start");
  chk_start_once: assert property (READ_DATA_START |=> !READ_DATA_START)
    else $error("read start longer than one cycle");
endmodule
bind sdram_mode_cfg sdram_mode_cfg_chk u_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .CK(CK), .CS_N(CS_N),
  .RAS_N(RAS_N), .CAS_N(CAS_N), .WE_N(WE_N), .BA(BA), .ADDR(ADDR), .THERMAL_HOT(THERMAL_HOT),
  .READ_DATA_START(READ_DATA_START), .READ_FROM_CALIB(READ_FROM_CALIB), .CALIB_LOCATION(CALIB_LOCATION),
  .RTT_WR_ACTIVE(RTT_WR_ACTIVE), .SR_RATE_EXTENDED(SR_RATE_EXTENDED), .DLL_ENABLED(DLL_ENABLED));

/* tb/sdram_mode_cfg_tb.sv */
// self-checking bench for the mode-register block
`timescale 1ns/1ps
`include "sdram_mode_consts.svh"
`define CHK(g, e, m) begin checks++; if ((g) !== (e)) begin miscompares++; $display("unexpected at %0t: %s", $time, m); end end
module sdram_mode_cfg_tb;
  logic        clk_sys, rst_n, thermal_hot, ck, cs_n, ras_n, cas_n, we_n;
  logic        rd_start, rd_calib, wr_start, sr_ext, dll_en;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0]  calib_loc, rtt_wr, bresp, rresp, resp;
  logic [2:0]  ba;
  logic [14:0] addr, a;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rdat;
  logic [3:0]  wstrb;
  int          checks, miscompares, ck_cnt, cyc, cl, k;

  sdram_mode_cfg u_dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .CK(ck), .CS_N(cs_n), .RAS_N(ras_n), .CAS_N(cas_n),
    .WE_N(we_n), .BA(ba), .ADDR(addr), .THERMAL_HOT(thermal_hot), .READ_DATA_START(rd_start),
    .READ_FROM_CALIB(rd_calib), .WRITE_DATA_START(wr_start), .CALIB_LOCATION(calib_loc), .RTT_WR_ACTIVE(rtt_wr),
    .SR_RATE_EXTENDED(sr_ext), .DLL_ENABLED(dll_en), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  sdram_ctrl_model u_ctl (.ck(ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr));

  // ------------------------------------------------------------
  // clock, hang guard and bus tasks
  // ------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge ck) ck_cnt++;
  // a lost pulse or stuck handshake would otherwise hang the run
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic reset_dut();
    rst_n <= 1'b0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_sys);
    {awaddr, wdata} <= {ad, d};
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge clk_sys); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] ad);
    @(posedge clk_sys);
    araddr <= ad;
    {arvalid, rready} <= 2'h3;
    do @(posedge clk_sys); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_sys); while (rvalid !== 1'b1);
    {rdat, resp} = {rdata, rresp};
    rready <= 1'b0;
  endtask
  task automatic mrs(input logic [2:0] b, input logic [14:0] v);
    u_ctl.send(4'h0, b, v);
    repeat (4) @(posedge clk_sys);
  endtask
  // counts link edges from the command to its start pulse; a nop rides in between unless readout is on
  task automatic lat(input logic rd, input int exp, input logic calib);
    int c0;
    u_ctl.send(rd ? 4'h5 : 4'h4, 3'h0, 15'h0);
    c0 = ck_cnt;
    if (!calib) u_ctl.send(4'h7, 3'h0, 15'h0);
    do @(negedge clk_sys); while ((rd ? rd_start : wr_start) !== 1'b1);
    `CHK(ck_cnt - c0, exp, "start latency")
    if (rd) `CHK(rd_calib, calib, "readout source")
    @(posedge clk_sys);
  endtask
  function automatic int al_cyc(input int code, input int c);
    return code == 1 ? c - 1 : code == 2 ? c - 2 : 0;
  endfunction

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {rst_n, thermal_hot, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hf;
    void'($urandom(67968));
    reset_dut();
    `CHK(dll_en, 1'b1, "dll after reset")
    axi_rd(`OFS_LATENCY_STATUS);
    `CHK(rdat, 32'h0006_0500, "latency status reset")
    axi_wr(`OFS_MODE_STATUS, 32'hffff_ffff);
    `CHK(resp, `RESP_OKAY, "read-only write response")
    axi_rd(`OFS_MODE_STATUS);
    `CHK(rdat, 32'h0, "status is read-only")
    axi_rd(8'h40);
    `CHK(resp, `RESP_SLVERR, "unmapped address")
    $display("test reset done");
    for (int c = 0; c < 8; c++) begin
      a = (15'($urandom) & 15'h06c0) | 15'(c << 3);
      thermal_hot <= 1'($urandom);
      mrs(3'h2, a);
      `CHK(rtt_wr, a[10:9], "dynamic termination")
      `CHK(sr_ext, a[6] ? thermal_hot : a[7], "refresh rate")
      axi_rd(`OFS_MODE_STATUS);
      `CHK(rdat[6:4], c[2:0], "write delay code")
      lat(1'b0, 5 + c, 1'b0);
    end
    $display("test write delay done");
    for (int c = 0; c < 4; c++) begin
      mrs(3'h1, 15'(c << 3));
      lat(1'b1, al_cyc(c, 6) + 6, 1'b0);
      lat(1'b0, al_cyc(c, 6) + 12, 1'b0);
    end
    $display("test additive delay done");
    mrs(3'h2, 15'h0608);
    mrs(3'h1, 15'h0001);
    `CHK(dll_en, 1'b0, "dll disabled")
    lat(1'b1, 5, 1'b0);
    lat(1'b0, 6, 1'b0);
    mrs(3'h1, 15'h0081);
    `CHK(rtt_wr, 2'h0, "termination in leveling")
    mrs(3'h1, 15'h0000);
    `CHK(rtt_wr, 2'h3, "termination restored")
    `CHK(dll_en, 1'b1, "dll enabled")
    $display("test dll off done");
    a = 15'(1 + $urandom % 3);
    mrs(3'h3, a | 15'h4);
    `CHK(calib_loc, a[1:0], "readout location")
    lat(1'b1, 6, 1'b1);
    mrs(3'h3, a);
    `CHK(calib_loc, 2'h0, "location ignored")
    lat(1'b1, 6, 1'b0);
    mrs(3'h3, a | 15'h4);
    reset_dut();
    `CHK(calib_loc, 2'h0, "readout cleared by reset")
    lat(1'b1, 6, 1'b0);
    $display("test readout done");
    u_ctl.send(4'h8, 3'h1, 15'h0001);
    u_ctl.send(4'h7, 3'h1, 15'h0001);
    repeat (4) @(posedge clk_sys);
    `CHK(dll_en, 1'b1, "no command taken")
    $display("test idle commands done");
    repeat (6) begin
      cl = 5 + $urandom % 7;
      k = $urandom % 3;
      axi_wr(`OFS_LATENCY_CFG, 32'(cl));
      mrs(3'h1, 15'(k << 3));
      lat(1'b1, al_cyc(k, cl) + cl, 1'b0);
    end
    $display("test random latency done");
    summarize();
  end
endmodule
